// >>> logic/bdd_pkg.sv
// Package with modes, states and timing constants of the burst drive diagnostics block.
package bdd_pkg;
	localparam logic [1:0] MODE_SPI = 2'h0;
	localparam logic [1:0] MODE_PIN = 2'h1;
	localparam logic [1:0] MODE_DUAL = 2'h2;
	localparam logic [1:0] MODE_CLK = 2'h3;
	localparam logic [2:0] STUCK_CLEAR_CODE = 3'h7;
	localparam logic [5:0] FILTER_CODE_RESET = 6'h00;
	localparam logic [5:0] FILTER_CODE_MAX = 6'h2F;
	// Stuck timeout base step in ns; code n gives (n+1) steps.
	localparam int STUCK_STEP_NS = 10000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STUCK_STEP_CYC = (STUCK_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : (STUCK_STEP_NS / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		BDD_LISTEN = 2'b00,
		BDD_ARMED = 2'b01,
		BDD_BURST = 2'b10,
		BDD_BLANK = 2'b11
	} bdd_state_t;
endpackage

// >>> logic/bdd_top.sv
// Burst drive controller with pulse-count and stuck-drive diagnostics.
`timescale 1ns/1ps
module bdd_top #(
	parameter int COUNT_W = 8,
	parameter int STUCK_STEP = bdd_pkg::STUCK_STEP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [1:0] burst_mode_i,
	input wire logic [COUNT_W-1:0] pulse_count_i,
	input wire logic burst_request_i,
	input wire logic [2:0] stuck_timeout_select_i,
	input wire logic stuck_timeout_write_i,
	input wire logic single_side_drive_select_i,
	input wire logic predriver_select_i,
	input wire logic direct_sense_i,
	input wire logic standby_i,
	input wire logic [5:0] filter_center_code_i,
	input wire logic filter_center_write_i,
	input wire logic burst_control_pin_i,
	input wire logic burst_clock_pin_i,
	output logic drive_out_first_o,
	output logic drive_out_second_o,
	output logic bursting_o,
	output logic listening_o,
	output logic pulse_count_fault_flag_o,
	output logic stuck_drive_fault_flag_o,
	output logic [5:0] filter_center_code_o
);
	// The stuck timer is 24 bits wide and must hold eight timeout steps.
	if (COUNT_W < 1 || COUNT_W > 16 || STUCK_STEP < 1 || STUCK_STEP > 2097151) begin
		$error("bdd_top: unsupported parameter values");
	end

	logic [2:0] ctl_sync_ff;
	logic [2:0] clk_sync_ff;
	logic ctl_ff;
	logic clkp_ff;
	bdd_pkg::bdd_state_t state_ff;
	logic [COUNT_W-1:0] pulses_ff;
	logic [23:0] timer_ff;
	logic pcf_ff;
	logic sdf_ff;
	logic [5:0] fcode_ff;
	logic req_d_ff;
	logic drv_a_ff;
	logic drv_b_ff;

	// A pin change is accepted only once the second and third stages agree.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl_sync_ff <= 3'h7;
			clk_sync_ff <= 3'h7;
			ctl_ff <= 1'b1;
			clkp_ff <= 1'b1;
		end else begin
			ctl_sync_ff <= {ctl_sync_ff[1:0], burst_control_pin_i};
			clk_sync_ff <= {clk_sync_ff[1:0], burst_clock_pin_i};
			if (ctl_sync_ff[2] == ctl_sync_ff[1]) begin
				ctl_ff <= ctl_sync_ff[2];
			end
			if (clk_sync_ff[2] == clk_sync_ff[1]) begin
				clkp_ff <= clk_sync_ff[2];
			end
		end
	end

	logic clk_fall;
	logic clk_tog;
	logic ctl_fall;
	logic ctl_rise;
	logic ctl_tog;
	assign clk_fall = clkp_ff && clk_sync_ff[2] == clk_sync_ff[1] && !clk_sync_ff[2];
	assign clk_tog = clkp_ff != clk_sync_ff[2] && clk_sync_ff[2] == clk_sync_ff[1];
	assign ctl_fall = ctl_ff && ctl_sync_ff[2] == ctl_sync_ff[1] && !ctl_sync_ff[2];
	assign ctl_rise = !ctl_ff && ctl_sync_ff[2] == ctl_sync_ff[1] && ctl_sync_ff[2];
	assign ctl_tog = ctl_fall || ctl_rise;

	function automatic logic [23:0] stuck_limit(input logic [2:0] sel);
		stuck_limit = 24'((32'(sel) + 1) * STUCK_STEP);
	endfunction

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_d_ff <= 1'b0;
		end else begin
			req_d_ff <= burst_request_i;
		end
	end

	logic arm_ev;
	logic start_ev;
	logic count_done;
	logic ext_end;
	logic toggle_seen;
	logic stuck_ev;
	logic zero_cont;
	logic clear_all;
	always_comb begin
		unique case (burst_mode_i)
			bdd_pkg::MODE_SPI: arm_ev = burst_request_i && !req_d_ff;
			bdd_pkg::MODE_PIN: arm_ev = ctl_fall;
			bdd_pkg::MODE_DUAL: arm_ev = ctl_fall || clk_fall;
			bdd_pkg::MODE_CLK: arm_ev = clk_fall;
		endcase
	end
	// Mode 2 starts on the control pin, all others on the clock pin falling edge.
	assign start_ev = (burst_mode_i == bdd_pkg::MODE_DUAL) ? ctl_fall : clk_fall;
	assign zero_cont = pulse_count_i == '0 && burst_mode_i != bdd_pkg::MODE_CLK;
	// In mode 3 a zero count ends after the first pulse, so it never runs forever.
	assign count_done = burst_mode_i != bdd_pkg::MODE_DUAL && !zero_cont && clk_fall
		&& (pulses_ff + 1'b1 >= pulse_count_i);
	always_comb begin
		unique case (burst_mode_i)
			bdd_pkg::MODE_SPI: ext_end = !burst_request_i;
			bdd_pkg::MODE_PIN: ext_end = ctl_rise;
			bdd_pkg::MODE_DUAL: ext_end = ctl_ff && clkp_ff;
			bdd_pkg::MODE_CLK: ext_end = 1'b0;
		endcase
	end
	assign toggle_seen = (burst_mode_i == bdd_pkg::MODE_DUAL) ? (clk_tog || ctl_tog) : clk_tog;
	assign stuck_ev = state_ff == bdd_pkg::BDD_BURST && !toggle_seen
		&& timer_ff >= stuck_limit(stuck_timeout_select_i);
	assign clear_all = standby_i;

	// The count setting is not latched at start; pulses are compared against the live setting.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= bdd_pkg::BDD_LISTEN;
		end else if (standby_i) begin
			state_ff <= bdd_pkg::BDD_LISTEN;
		end else begin
			unique case (state_ff)
				bdd_pkg::BDD_LISTEN: if (arm_ev) begin
					state_ff <= (burst_mode_i == bdd_pkg::MODE_CLK) ? bdd_pkg::BDD_BURST : bdd_pkg::BDD_ARMED;
				end
				bdd_pkg::BDD_ARMED: if (start_ev) begin
					state_ff <= bdd_pkg::BDD_BURST;
				end else if (ext_end && burst_mode_i != bdd_pkg::MODE_DUAL) begin
					state_ff <= bdd_pkg::BDD_LISTEN;
				end
				bdd_pkg::BDD_BURST: if (stuck_ev || count_done || ext_end) begin
					state_ff <= (burst_mode_i == bdd_pkg::MODE_CLK) ? bdd_pkg::BDD_BLANK : bdd_pkg::BDD_LISTEN;
				end
				bdd_pkg::BDD_BLANK: if (timer_ff >= stuck_limit(stuck_timeout_select_i)) begin
					state_ff <= bdd_pkg::BDD_LISTEN;
				end
			endcase
		end
	end

	logic burst_start;
	logic burst_end;
	assign burst_start = (state_ff == bdd_pkg::BDD_ARMED && start_ev)
		|| (state_ff == bdd_pkg::BDD_LISTEN && arm_ev && burst_mode_i == bdd_pkg::MODE_CLK);
	assign burst_end = state_ff == bdd_pkg::BDD_BURST && (stuck_ev || count_done || ext_end);

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pulses_ff <= '0;
			timer_ff <= 24'h000000;
		end else begin
			if (burst_start) begin
				pulses_ff <= '0;
			end else if (state_ff == bdd_pkg::BDD_BURST && clk_fall && pulses_ff != '1) begin
				pulses_ff <= pulses_ff + 1'b1;
			end
			// Toggles rearm the timer only inside a burst, so the blank-out runs out while the clock keeps going.
			if (burst_start || burst_end || (toggle_seen && state_ff == bdd_pkg::BDD_BURST)
				|| state_ff == bdd_pkg::BDD_LISTEN) begin
				timer_ff <= 24'h000000;
			end else if (timer_ff != 24'hFFFFFF) begin
				timer_ff <= timer_ff + 24'h000001;
			end
		end
	end

	logic short_end;
	assign short_end = burst_end && !count_done && burst_mode_i != bdd_pkg::MODE_DUAL
		&& !(zero_cont && !stuck_ev);
	// Sets win over clears arriving in the same cycle.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pcf_ff <= 1'b0;
			sdf_ff <= 1'b0;
		end else begin
			if (short_end) begin
				pcf_ff <= 1'b1;
			end else if (burst_start || clear_all) begin
				pcf_ff <= 1'b0;
			end
			if (stuck_ev) begin
				sdf_ff <= 1'b1;
			end else if (burst_start || clear_all
				|| (stuck_timeout_write_i && stuck_timeout_select_i == bdd_pkg::STUCK_CLEAR_CODE)) begin
				sdf_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fcode_ff <= bdd_pkg::FILTER_CODE_RESET;
		end else if (filter_center_write_i && filter_center_code_i <= bdd_pkg::FILTER_CODE_MAX) begin
			fcode_ff <= filter_center_code_i;
		end
	end

	// Drive follows the burst clock pin; mode 2 follows the control pin, and pairs it with the clock pin only under pre-driver select.
	logic phase;
	logic next_a;
	logic next_b;
	always_comb begin
		phase = (burst_mode_i == bdd_pkg::MODE_DUAL) ? !ctl_ff : !clkp_ff;
		next_a = 1'b0;
		next_b = 1'b0;
		if (state_ff == bdd_pkg::BDD_BURST && !burst_end) begin
			if (predriver_select_i) begin
				next_a = phase;
				next_b = (burst_mode_i == bdd_pkg::MODE_DUAL) ? !clkp_ff : !phase;
			end else if (single_side_drive_select_i) begin
				next_a = phase;
				next_b = 1'b0;
			end else begin
				next_a = phase;
				next_b = !phase;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drv_a_ff <= 1'b0;
			drv_b_ff <= 1'b0;
			bursting_o <= 1'b0;
			listening_o <= 1'b1;
		end else begin
			drv_a_ff <= next_a;
			drv_b_ff <= next_b;
			bursting_o <= state_ff == bdd_pkg::BDD_BURST;
			listening_o <= state_ff != bdd_pkg::BDD_BURST && !direct_sense_i;
		end
	end
	assign drive_out_first_o = drv_a_ff;
	assign drive_out_second_o = drv_b_ff;
	assign pulse_count_fault_flag_o = pcf_ff;
	assign stuck_drive_fault_flag_o = sdf_ff;
	assign filter_center_code_o = fcode_ff;

	property p_stuck_sets_flag;
		@(posedge clk_sys_i) disable iff (!reset_n_i) stuck_ev |=> sdf_ff;
	endproperty
	a_stuck_sets_flag: assert property (p_stuck_sets_flag) else $error("stuck flag not set");
	sequence s_drive_released;
		state_ff != bdd_pkg::BDD_BURST ##1 (!drv_a_ff && !drv_b_ff);
	endsequence
	property p_stuck_ends;
		@(posedge clk_sys_i) disable iff (!reset_n_i) stuck_ev |=> s_drive_released;
	endproperty
	a_stuck_ends: assert property (p_stuck_ends) else $error("burst not forced off");
	property p_short_count;
		@(posedge clk_sys_i) disable iff (!reset_n_i) short_end |=> pcf_ff;
	endproperty
	a_short_count: assert property (p_short_count) else $error("count fault missing");
	property p_sdf_sticky;
		@(posedge clk_sys_i) disable iff (!reset_n_i) sdf_ff && !burst_start && !standby_i && !stuck_timeout_write_i |=> sdf_ff;
	endproperty
	a_sdf_sticky: assert property (p_sdf_sticky) else $error("stuck flag dropped");
	property p_pcf_clear;
		@(posedge clk_sys_i) disable iff (!reset_n_i) standby_i && !short_end |=> !pcf_ff;
	endproperty
	a_pcf_clear: assert property (p_pcf_clear) else $error("count flag kept in standby");
	property p_code7;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
			stuck_timeout_write_i && stuck_timeout_select_i == bdd_pkg::STUCK_CLEAR_CODE && !stuck_ev |=> !sdf_ff;
	endproperty
	a_code7: assert property (p_code7) else $error("code 7 did not clear");
	property p_single;
		@(posedge clk_sys_i) disable iff (!reset_n_i) single_side_drive_select_i && !predriver_select_i |=> !drv_b_ff;
	endproperty
	a_single: assert property (p_single) else $error("second side driven");
	property p_full;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
			state_ff == bdd_pkg::BDD_BURST && !burst_end && !single_side_drive_select_i && !predriver_select_i
			|=> drv_a_ff != drv_b_ff;
	endproperty
	a_full: assert property (p_full) else $error("sides not opposite");
endmodule

// >>> tb/bdd_mcu_model.sv
// Microcontroller model that makes the burst clock pin.
`timescale 1ns/1ps
module bdd_mcu_model #(
	parameter int HALF = 8
) (
	input wire logic clk_sys_i,
	input wire logic run_i,
	output logic burst_clock_pin_o
);
	int cnt = 0;
	logic pin = 1'b1;
	assign burst_clock_pin_o = pin;
	// The pin rests high outside frames, so a stopped clock also reads as stuck.
	always @(posedge clk_sys_i) begin
		if (!run_i) begin
			cnt <= 0;
			pin <= 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			pin <= ~pin;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the burst drive diagnostics block.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] count = 8'h00;
	logic [2:0] tsel = 3'h3;
	logic [5:0] fcode = 6'h00;
	logic req = 1'b0, twr = 1'b0, single = 1'b0, stby = 1'b0;
	logic fwr = 1'b0, ctrl = 1'b1, run = 1'b0;
	logic pre = 1'b0, direct = 1'b0;
	logic clk_pin, d1, d2, bursting, listening, pflt, sflt;
	logic [5:0] fout;
	int fail_count = 0;
	int tests_run = 0;
	int blen = 0, d1h = 0, d2h = 0, both = 0;

	initial forever #5 clk_sys_i = ~clk_sys_i;

	bdd_mcu_model #(.HALF(8)) u_mcu (.clk_sys_i(clk_sys_i), .run_i(run), .burst_clock_pin_o(clk_pin));

	bdd_top #(.COUNT_W(8), .STUCK_STEP(4)) u_dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .burst_mode_i(mode), .pulse_count_i(count),
		.burst_request_i(req), .stuck_timeout_select_i(tsel), .stuck_timeout_write_i(twr),
		.single_side_drive_select_i(single), .predriver_select_i(pre), .direct_sense_i(direct),
		.standby_i(stby), .filter_center_code_i(fcode), .filter_center_write_i(fwr),
		.burst_control_pin_i(ctrl), .burst_clock_pin_i(clk_pin), .drive_out_first_o(d1),
		.drive_out_second_o(d2), .bursting_o(bursting), .listening_o(listening),
		.pulse_count_fault_flag_o(pflt), .stuck_drive_fault_flag_o(sflt), .filter_center_code_o(fout)
	);

	always @(posedge clk_sys_i) begin
		if (bursting === 1'b1) blen++;
		if (d1 === 1'b1) d1h++;
		if (d2 === 1'b1) d2h++;
		if (d1 === 1'b1 && d2 === 1'b1) both++;
	end

	task automatic tally_and_finish;
		if (fail_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic chk_code(input logic [5:0] got, input logic [5:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// Samples mid-cycle so registered outputs have settled, then returns on a rising edge.
	task automatic wait_burst(input logic v);
		int i;
		i = 0;
		@(negedge clk_sys_i);
		while (bursting !== v && i < 600) begin
			@(negedge clk_sys_i);
			i++;
		end
		chk_bit(bursting, v, "burst state wait");
		@(posedge clk_sys_i);
	endtask

	task automatic wr_filter(input logic [5:0] c, input logic [5:0] exp);
		fcode <= c;
		fwr <= 1'b1;
		cyc(1);
		fwr <= 1'b0;
		cyc(2);
		@(negedge clk_sys_i);
		chk_code(fout, exp, "filter code");
		@(posedge clk_sys_i);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		cyc(12);
		reset_n_i <= 1'b1;
		cyc(4);
		@(negedge clk_sys_i);
		chk_bit(listening, 1'b1, "listen after reset");
		chk_code(fout, 6'h00, "filter reset value");
		@(posedge clk_sys_i);
		wr_filter(6'h15, 6'h15);
		wr_filter(6'h30, 6'h15);
		direct <= 1'b1;
		cyc(3);
		chk_bit(listening, 1'b0, "direct sensing is not listening");
		direct <= 1'b0;
		cyc(3);
		chk_bit(listening, 1'b1, "listening again after direct sensing");
		count <= 8'h03;
		req <= 1'b1;
		run <= 1'b1;
		wait_burst(1'b1);
		blen = 0;
		wait_burst(1'b0);
		chk_bit(blen >= 40 && blen <= 56, 1'b1, "three pulse length");
		chk_bit(pflt, 1'b0, "no count fault on full burst");
		chk_bit(listening, 1'b1, "listen after burst");
		chk_bit(both == 0 && d1h > 0, 1'b1, "two sides out of phase");
		req <= 1'b0;
		run <= 1'b0;
		cyc(4);
		pre <= 1'b1;
		both = 0;
		d2h = 0;
		req <= 1'b1;
		run <= 1'b1;
		wait_burst(1'b1);
		wait_burst(1'b0);
		chk_bit(both == 0 && d2h > 0, 1'b1, "pre-driver switches alternate");
		pre <= 1'b0;
		req <= 1'b0;
		run <= 1'b0;
		cyc(4);
		count <= 8'h05;
		req <= 1'b1;
		run <= 1'b1;
		wait_burst(1'b1);
		cyc(32);
		req <= 1'b0;
		wait_burst(1'b0);
		cyc(20);
		chk_bit(pflt, 1'b1, "short burst count fault");
		chk_bit(sflt, 1'b0, "no stuck fault");
		run <= 1'b0;
		count <= 8'h0A;
		single <= 1'b1;
		cyc(4);
		req <= 1'b1;
		run <= 1'b1;
		d2h = 0;
		wait_burst(1'b1);
		cyc(2);
		chk_bit(pflt, 1'b0, "start clears count fault");
		cyc(30);
		run <= 1'b0;
		blen = 0;
		wait_burst(1'b0);
		chk_bit(blen <= 24, 1'b1, "stuck ends burst at once");
		chk_bit(sflt, 1'b1, "stuck fault");
		chk_bit(pflt, 1'b1, "stuck also count fault");
		chk_bit(d2h == 0, 1'b1, "single side drive");
		req <= 1'b0;
		single <= 1'b0;
		tsel <= 3'h7;
		twr <= 1'b1;
		cyc(1);
		twr <= 1'b0;
		cyc(2);
		chk_bit(sflt, 1'b0, "code seven clears stuck");
		chk_bit(pflt, 1'b1, "count fault kept");
		tsel <= 3'h3;
		stby <= 1'b1;
		cyc(2);
		chk_bit(pflt, 1'b0, "standby clears count fault");
		stby <= 1'b0;
		count <= 8'h00;
		req <= 1'b1;
		run <= 1'b1;
		wait_burst(1'b1);
		cyc(300);
		chk_bit(bursting, 1'b1, "continuous via request");
		req <= 1'b0;
		wait_burst(1'b0);
		mode <= 2'h1;
		ctrl <= 1'b0;
		wait_burst(1'b1);
		cyc(300);
		chk_bit(bursting, 1'b1, "continuous via pin");
		ctrl <= 1'b1;
		wait_burst(1'b0);
		// Let the clock pin settle high before mode 3, so a late fall cannot start a burst.
		run <= 1'b0;
		cyc(8);
		mode <= 2'h3;
		tsel <= 3'h7;
		cyc(4);
		run <= 1'b1;
		wait_burst(1'b1);
		wait_burst(1'b0);
		cyc(20);
		chk_bit(bursting, 1'b0, "blank-out holds off restart");
		wait_burst(1'b1);
		wait_burst(1'b0);
		run <= 1'b0;
		cyc(40);
		mode <= 2'h2;
		count <= 8'h01;
		ctrl <= 1'b0;
		cyc(8);
		ctrl <= 1'b1;
		cyc(8);
		ctrl <= 1'b0;
		run <= 1'b1;
		wait_burst(1'b1);
		cyc(100);
		chk_bit(bursting, 1'b1, "dual pin ignores count");
		ctrl <= 1'b1;
		wait_burst(1'b0);
		chk_bit(pflt, 1'b0, "no count fault in dual pin mode");
		run <= 1'b0;
		cyc(4);
		tally_and_finish();
	end
endmodule
